// file: common/serr_mask_pkg.sv
package serr_mask_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int EVT_W = 8;
  // Register offsets on the byte-addressed register port.
  localparam logic [7:0] DISABLE_OFFSET = 8'h64;
  localparam logic [7:0] CAUSE_OFFSET = 8'h68;
  localparam logic [7:0] IRQ_MASK_OFFSET = 8'h6C;
  // Reset values.
  localparam logic [7:0] DISABLE_RESET = 8'h00;
  localparam logic [7:0] CAUSE_RESET = 8'h00;
  localparam logic [7:0] IRQ_MASK_RESET = 8'h00;
  localparam logic [31:0] RDATA_RESET = 32'h00000000;
  // Only bits 1 to 6 carry events; bits 0 and 7 are reserved.
  localparam logic [7:0] EVENT_BITS = 8'h7E;
  // Field positions, shared by disable, cause and mask registers.
  localparam int RSVD_LO_BIT = 0;
  localparam int PW_PARITY_BIT = 1;
  localparam int PW_NODELIVER_BIT = 2;
  localparam int PW_TGT_ABORT_BIT = 3;
  localparam int PW_MST_ABORT_BIT = 4;
  localparam int DW_NODELIVER_BIT = 5;
  localparam int DR_NODATA_BIT = 6;
  localparam int RSVD_HI_BIT = 7;
endpackage

// file: common/serr_gate_if.sv
`timescale 1ns/100ps
interface serr_gate_if #(parameter int W = 8);
  logic [W-1:0] event_level;
  logic [W-1:0] disable_bits;
  logic serr_enable;
  logic [W-1:0] report;
  logic serr_n;
  modport ctrl (
    output event_level,
    output disable_bits,
    output serr_enable,
    input report,
    input serr_n
  );
  modport gate (
    input event_level,
    input disable_bits,
    input serr_enable,
    output report,
    output serr_n
  );
endinterface // serr_gate_if

// file: rtl/flag_bank.sv
`timescale 1ns/100ps
module flag_bank import serr_mask_pkg::*; #(
  parameter int W = EVT_W
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Set and write-one-to-clear vectors
  input wire logic [W-1:0] set_in,
  input wire logic [W-1:0] clr_in,
  // Sticky flags
  output logic [W-1:0] flags_out
);
  typedef struct packed {
    logic [W-1:0] flags;
  } bank_state_t;

  bank_state_t s_q;
  bank_state_t s_d;

  // A set in the same cycle as its clear wins, so no event is lost.
  always_comb begin
    s_d = s_q;
    s_d.flags = (s_q.flags & ~clr_in) | set_in;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q.flags <= W'(CAUSE_RESET);
    end else begin
      s_q <= s_d;
    end
  end

  assign flags_out = s_q.flags;
endmodule // flag_bank

// file: rtl/serr_gate.sv
`timescale 1ns/100ps
module serr_gate import serr_mask_pkg::*; #(
  parameter int W = EVT_W
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Gating path
  serr_gate_if.gate gate_io
);
  typedef struct packed {
    logic serr_n;
  } gate_state_t;

  gate_state_t s_q;
  gate_state_t s_d;

  always_comb begin
    s_d = s_q;
    // A set disable bit removes its event whatever the enable says.
    gate_io.report = gate_io.event_level & ~gate_io.disable_bits & W'(EVENT_BITS)
                     & {W{gate_io.serr_enable}};
    s_d.serr_n = ~(|gate_io.report);
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q.serr_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign gate_io.serr_n = s_q.serr_n;
endmodule // serr_gate

// file: rtl/system_error_event_mask.sv
`timescale 1ns/100ps
module system_error_event_mask import serr_mask_pkg::*; (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Register port
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [DATA_W-1:0] rdata_out,
  // Error event conditions and command register enable
  input wire logic [EVT_W-1:0] event_in,
  input wire logic serr_enable_in,
  // System error and interrupt
  output logic serr_n_out,
  output logic irq_out
);
  typedef struct packed {
    logic [EVT_W-1:0] dis;
    logic [EVT_W-1:0] mask;
    logic [DATA_W-1:0] rdata;
    logic irq;
  } top_state_t;

  top_state_t s_q;
  top_state_t s_d;
  logic [EVT_W-1:0] cause_flags;
  logic [EVT_W-1:0] cause_clr;

  serr_gate_if #(.W(EVT_W)) gate_bus ();

  assign gate_bus.event_level = event_in;
  assign gate_bus.disable_bits = s_q.dis;
  assign gate_bus.serr_enable = serr_enable_in;

  serr_gate #(.W(EVT_W)) u_gate (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .gate_io(gate_bus)
  );

  // Writing a one clears a cause flag; the reserved bits never hold one.
  assign cause_clr = (wr_in && addr_in == CAUSE_OFFSET) ? (wdata_in[EVT_W-1:0] & EVENT_BITS) : '0;

  flag_bank #(.W(EVT_W)) u_cause (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .set_in(gate_bus.report),
    .clr_in(cause_clr),
    .flags_out(cause_flags)
  );

  always_comb begin
    s_d = s_q;
    s_d.rdata = RDATA_RESET;
    if (wr_in) begin
      case (addr_in)
        DISABLE_OFFSET: begin
          s_d.dis = wdata_in[EVT_W-1:0] & EVENT_BITS;
        end
        IRQ_MASK_OFFSET: begin
          s_d.mask = wdata_in[EVT_W-1:0] & EVENT_BITS;
        end
        default: begin
        end
      endcase
    end
    // Unmapped addresses read as zero so software can probe safely.
    if (rd_in) begin
      case (addr_in)
        DISABLE_OFFSET: s_d.rdata = {24'h000000, s_q.dis};
        CAUSE_OFFSET: s_d.rdata = {24'h000000, cause_flags};
        IRQ_MASK_OFFSET: s_d.rdata = {24'h000000, s_q.mask};
        default: s_d.rdata = RDATA_RESET;
      endcase
    end
    // The interrupt follows the flags one cycle later to keep the output registered.
    s_d.irq = |(cause_flags & s_q.mask);
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q.dis <= DISABLE_RESET;
      s_q.mask <= IRQ_MASK_RESET;
      s_q.rdata <= RDATA_RESET;
      s_q.irq <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata_out = s_q.rdata;
  assign irq_out = s_q.irq;
  assign serr_n_out = gate_bus.serr_n;

  // Helper terms read only by the checks below.
  logic [EVT_W-1:0] live_evt;
  logic live_any;
  assign live_evt = event_in & ~s_q.dis & EVENT_BITS;
  assign live_any = (|live_evt) && serr_enable_in;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  property p_rsvd_lo;
    (rd_in && addr_in == DISABLE_OFFSET) |=> (rdata_out[RSVD_LO_BIT] == 1'b0);
  endproperty
  a_rsvd_lo: assert property (p_rsvd_lo) else $error("Reserved bit 0 read back as one.");

  property p_pw_parity;
    (event_in[PW_PARITY_BIT] && !s_q.dis[PW_PARITY_BIT] && serr_enable_in) |=> !serr_n_out;
  endproperty
  a_pw_parity: assert property (p_pw_parity) else $error("Parity event not reported.");

  property p_pw_nodeliver;
    (event_in[PW_NODELIVER_BIT] && !s_q.dis[PW_NODELIVER_BIT] && serr_enable_in)
      |-> ##1 (!serr_n_out && cause_flags[PW_NODELIVER_BIT]);
  endproperty
  a_pw_nodeliver: assert property (p_pw_nodeliver) else $error("Posted nondelivery not reported.");

  property p_pw_tgt_abort;
    (event_in[PW_TGT_ABORT_BIT] && !s_q.dis[PW_TGT_ABORT_BIT] && serr_enable_in) |=> !serr_n_out;
  endproperty
  a_pw_tgt_abort: assert property (p_pw_tgt_abort) else $error("Target abort not reported.");

  property p_pw_mst_abort;
    (event_in[PW_MST_ABORT_BIT] && !s_q.dis[PW_MST_ABORT_BIT] && serr_enable_in)
      |=> (!serr_n_out && cause_flags[PW_MST_ABORT_BIT]);
  endproperty
  a_pw_mst_abort: assert property (p_pw_mst_abort) else $error("Master abort not reported.");

  property p_dw_nodeliver;
    (event_in[DW_NODELIVER_BIT] && !s_q.dis[DW_NODELIVER_BIT] && serr_enable_in) |=> !serr_n_out;
  endproperty
  a_dw_nodeliver: assert property (p_dw_nodeliver) else $error("Delayed write loss not reported.");

  property p_dr_nodata;
    (event_in[DR_NODATA_BIT] && s_q.dis[DR_NODATA_BIT] && live_evt == 8'h00)
      |=> serr_n_out;
  endproperty
  a_dr_nodata: assert property (p_dr_nodata) else $error("Disabled delayed read was reported.");

  property p_need_enable;
    !serr_enable_in |=> (serr_n_out && ((cause_flags & ~$past(cause_flags)) == 8'h00));
  endproperty
  a_need_enable: assert property (p_need_enable) else $error("Error asserted without enable.");

  property p_disabled_quiet;
    (live_evt == 8'h00) |=> serr_n_out;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) else $error("Disabled event asserted error.");

  property p_rsvd_hi;
    (wr_in && addr_in == DISABLE_OFFSET && wdata_in[RSVD_HI_BIT]) ##1 (rd_in && addr_in == DISABLE_OFFSET)
      |=> (rdata_out[RSVD_HI_BIT] == 1'b0);
  endproperty
  a_rsvd_hi: assert property (p_rsvd_hi) else $error("Reserved bit 7 read back as one.");

  property p_cause_set;
    live_any |=> ((cause_flags & $past(live_evt)) == $past(live_evt));
  endproperty
  a_cause_set: assert property (p_cause_set) else $error("Cause flag not set on report.");

  property p_or_output;
    1'b1 |=> (serr_n_out == !$past(live_any));
  endproperty
  a_or_output: assert property (p_or_output) else $error("Error output not OR of live events.");

  // Each event field is written, suppressed, held and cleared on its own.
  // A fault in one field could otherwise hide behind the OR of the others.
  property p_dis_wr_parity;
    (wr_in && addr_in == DISABLE_OFFSET) |=> (s_q.dis[PW_PARITY_BIT] == $past(wdata_in[PW_PARITY_BIT]));
  endproperty
  a_dis_wr_parity: assert property (p_dis_wr_parity) else $error("Parity disable bit not written.");

  property p_dis_wr_pw_nodeliver;
    (wr_in && addr_in == DISABLE_OFFSET) |=> (s_q.dis[PW_NODELIVER_BIT] == $past(wdata_in[PW_NODELIVER_BIT]));
  endproperty
  a_dis_wr_pw_nodeliver: assert property (p_dis_wr_pw_nodeliver) else $error("Posted loss bit not written.");

  property p_dis_wr_tgt_abort;
    (wr_in && addr_in == DISABLE_OFFSET) |=> (s_q.dis[PW_TGT_ABORT_BIT] == $past(wdata_in[PW_TGT_ABORT_BIT]));
  endproperty
  a_dis_wr_tgt_abort: assert property (p_dis_wr_tgt_abort) else $error("Target abort bit not written.");

  property p_dis_wr_mst_abort;
    (wr_in && addr_in == DISABLE_OFFSET) |=> (s_q.dis[PW_MST_ABORT_BIT] == $past(wdata_in[PW_MST_ABORT_BIT]));
  endproperty
  a_dis_wr_mst_abort: assert property (p_dis_wr_mst_abort) else $error("Master abort bit not written.");

  property p_dis_wr_dw_nodeliver;
    (wr_in && addr_in == DISABLE_OFFSET) |=> (s_q.dis[DW_NODELIVER_BIT] == $past(wdata_in[DW_NODELIVER_BIT]));
  endproperty
  a_dis_wr_dw_nodeliver: assert property (p_dis_wr_dw_nodeliver) else $error("Delayed write bit not written.");

  property p_dis_wr_dr_nodata;
    (wr_in && addr_in == DISABLE_OFFSET) |=> (s_q.dis[DR_NODATA_BIT] == $past(wdata_in[DR_NODATA_BIT]));
  endproperty
  a_dis_wr_dr_nodata: assert property (p_dis_wr_dr_nodata) else $error("Delayed read bit not written.");

  property p_quiet_parity;
    (event_in[PW_PARITY_BIT] && s_q.dis[PW_PARITY_BIT])
      |=> (!cause_flags[PW_PARITY_BIT] || $past(cause_flags[PW_PARITY_BIT]));
  endproperty
  a_quiet_parity: assert property (p_quiet_parity) else $error("Disabled parity event set its flag.");

  property p_quiet_pw_nodeliver;
    (event_in[PW_NODELIVER_BIT] && s_q.dis[PW_NODELIVER_BIT])
      |=> (!cause_flags[PW_NODELIVER_BIT] || $past(cause_flags[PW_NODELIVER_BIT]));
  endproperty
  a_quiet_pw_nodeliver: assert property (p_quiet_pw_nodeliver) else $error("Disabled posted loss set its flag.");

  property p_quiet_tgt_abort;
    (event_in[PW_TGT_ABORT_BIT] && s_q.dis[PW_TGT_ABORT_BIT])
      |=> (!cause_flags[PW_TGT_ABORT_BIT] || $past(cause_flags[PW_TGT_ABORT_BIT]));
  endproperty
  a_quiet_tgt_abort: assert property (p_quiet_tgt_abort) else $error("Disabled target abort set its flag.");

  property p_quiet_mst_abort;
    (event_in[PW_MST_ABORT_BIT] && s_q.dis[PW_MST_ABORT_BIT])
      |=> (!cause_flags[PW_MST_ABORT_BIT] || $past(cause_flags[PW_MST_ABORT_BIT]));
  endproperty
  a_quiet_mst_abort: assert property (p_quiet_mst_abort) else $error("Disabled master abort set its flag.");

  property p_quiet_dw_nodeliver;
    (event_in[DW_NODELIVER_BIT] && s_q.dis[DW_NODELIVER_BIT])
      |=> (!cause_flags[DW_NODELIVER_BIT] || $past(cause_flags[DW_NODELIVER_BIT]));
  endproperty
  a_quiet_dw_nodeliver: assert property (p_quiet_dw_nodeliver) else $error("Disabled write loss set its flag.");

  property p_quiet_dr_nodata;
    (event_in[DR_NODATA_BIT] && s_q.dis[DR_NODATA_BIT])
      |=> (!cause_flags[DR_NODATA_BIT] || $past(cause_flags[DR_NODATA_BIT]));
  endproperty
  a_quiet_dr_nodata: assert property (p_quiet_dr_nodata) else $error("Disabled read loss set its flag.");

  property p_clr_parity;
    (cause_clr[PW_PARITY_BIT] && !(live_evt[PW_PARITY_BIT] && serr_enable_in))
      |=> !cause_flags[PW_PARITY_BIT];
  endproperty
  a_clr_parity: assert property (p_clr_parity) else $error("Parity flag not cleared.");

  property p_clr_pw_nodeliver;
    (cause_clr[PW_NODELIVER_BIT] && !(live_evt[PW_NODELIVER_BIT] && serr_enable_in))
      |=> !cause_flags[PW_NODELIVER_BIT];
  endproperty
  a_clr_pw_nodeliver: assert property (p_clr_pw_nodeliver) else $error("Posted loss flag not cleared.");

  property p_clr_tgt_abort;
    (cause_clr[PW_TGT_ABORT_BIT] && !(live_evt[PW_TGT_ABORT_BIT] && serr_enable_in))
      |=> !cause_flags[PW_TGT_ABORT_BIT];
  endproperty
  a_clr_tgt_abort: assert property (p_clr_tgt_abort) else $error("Target abort flag not cleared.");

  property p_clr_mst_abort;
    (cause_clr[PW_MST_ABORT_BIT] && !(live_evt[PW_MST_ABORT_BIT] && serr_enable_in))
      |=> !cause_flags[PW_MST_ABORT_BIT];
  endproperty
  a_clr_mst_abort: assert property (p_clr_mst_abort) else $error("Master abort flag not cleared.");

  property p_clr_dw_nodeliver;
    (cause_clr[DW_NODELIVER_BIT] && !(live_evt[DW_NODELIVER_BIT] && serr_enable_in))
      |=> !cause_flags[DW_NODELIVER_BIT];
  endproperty
  a_clr_dw_nodeliver: assert property (p_clr_dw_nodeliver) else $error("Write loss flag not cleared.");

  property p_clr_dr_nodata;
    (cause_clr[DR_NODATA_BIT] && !(live_evt[DR_NODATA_BIT] && serr_enable_in))
      |=> !cause_flags[DR_NODATA_BIT];
  endproperty
  a_clr_dr_nodata: assert property (p_clr_dr_nodata) else $error("Read loss flag not cleared.");

  property p_hold_parity;
    (cause_flags[PW_PARITY_BIT] && !cause_clr[PW_PARITY_BIT]) |=> cause_flags[PW_PARITY_BIT];
  endproperty
  a_hold_parity: assert property (p_hold_parity) else $error("Parity flag lost.");

  property p_hold_pw_nodeliver;
    (cause_flags[PW_NODELIVER_BIT] && !cause_clr[PW_NODELIVER_BIT]) |=> cause_flags[PW_NODELIVER_BIT];
  endproperty
  a_hold_pw_nodeliver: assert property (p_hold_pw_nodeliver) else $error("Posted loss flag lost.");

  property p_hold_tgt_abort;
    (cause_flags[PW_TGT_ABORT_BIT] && !cause_clr[PW_TGT_ABORT_BIT]) |=> cause_flags[PW_TGT_ABORT_BIT];
  endproperty
  a_hold_tgt_abort: assert property (p_hold_tgt_abort) else $error("Target abort flag lost.");

  property p_hold_mst_abort;
    (cause_flags[PW_MST_ABORT_BIT] && !cause_clr[PW_MST_ABORT_BIT]) |=> cause_flags[PW_MST_ABORT_BIT];
  endproperty
  a_hold_mst_abort: assert property (p_hold_mst_abort) else $error("Master abort flag lost.");

  property p_hold_dw_nodeliver;
    (cause_flags[DW_NODELIVER_BIT] && !cause_clr[DW_NODELIVER_BIT]) |=> cause_flags[DW_NODELIVER_BIT];
  endproperty
  a_hold_dw_nodeliver: assert property (p_hold_dw_nodeliver) else $error("Write loss flag lost.");

  property p_hold_dr_nodata;
    (cause_flags[DR_NODATA_BIT] && !cause_clr[DR_NODATA_BIT]) |=> cause_flags[DR_NODATA_BIT];
  endproperty
  a_hold_dr_nodata: assert property (p_hold_dr_nodata) else $error("Read loss flag lost.");

  property p_dis_lo_wr;
    (wr_in && addr_in == DISABLE_OFFSET && wdata_in[RSVD_LO_BIT]) |=> !s_q.dis[RSVD_LO_BIT];
  endproperty
  a_dis_lo_wr: assert property (p_dis_lo_wr) else $error("Reserved bit 0 took a write.");

  property p_dis_hi_wr;
    (wr_in && addr_in == DISABLE_OFFSET && wdata_in[RSVD_HI_BIT]) |=> !s_q.dis[RSVD_HI_BIT];
  endproperty
  a_dis_hi_wr: assert property (p_dis_hi_wr) else $error("Reserved bit 7 took a write.");

  property p_mask_rsvd;
    (wr_in && addr_in == IRQ_MASK_OFFSET) |=> (!s_q.mask[RSVD_LO_BIT] && !s_q.mask[RSVD_HI_BIT]);
  endproperty
  a_mask_rsvd: assert property (p_mask_rsvd) else $error("Reserved mask bit took a write.");

  property p_rd_dis;
    (rd_in && addr_in == DISABLE_OFFSET) |=> (rdata_out == {24'h000000, $past(s_q.dis)});
  endproperty
  a_rd_dis: assert property (p_rd_dis) else $error("Disable register read back wrong.");

  property p_rd_cause;
    (rd_in && addr_in == CAUSE_OFFSET) |=> (rdata_out == {24'h000000, $past(cause_flags)});
  endproperty
  a_rd_cause: assert property (p_rd_cause) else $error("Cause register read back wrong.");

  property p_rdata_idle;
    !rd_in |=> (rdata_out == RDATA_RESET);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("Read data stood without a read.");

  property p_irq_level;
    1'b1 |=> (irq_out == (|($past(cause_flags) & $past(s_q.mask))));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("Interrupt does not follow flags.");

  c_disabled_event: cover property ((event_in & s_q.dis) != 8'h00 && serr_enable_in);
  c_report: cover property (live_any ##1 !serr_n_out);
  c_suppressed: cover property ((event_in & EVENT_BITS) != 8'h00 && serr_enable_in && !live_any);
  c_cause_clear: cover property (cause_flags != 8'h00 ##1 cause_clr != 8'h00 ##1 cause_flags == 8'h00);
  c_irq: cover property (!irq_out ##1 irq_out);
endmodule // system_error_event_mask

// file: dv/serr_host_model.sv
`timescale 1ns/100ps
module serr_host_model (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // System error line from the bridge
  input wire logic serr_n_in,
  // Count of cycles the line was seen low
  output logic [15:0] low_cycles_out
);
  // The host only samples the line on its own clock, so glitches between edges are not counted.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      low_cycles_out <= 16'h0000;
    end else if (serr_n_in === 1'b0) begin
      low_cycles_out <= low_cycles_out + 16'h0001;
    end
  end
endmodule // serr_host_model

// file: dv/system_error_event_mask_tb.sv
`timescale 1ns/100ps
module system_error_event_mask_tb import serr_mask_pkg::*;;
  logic clk_in;
  logic rst_n_in;
  logic [ADDR_W-1:0] addr_in;
  logic [DATA_W-1:0] wdata_in;
  logic wr_in;
  logic rd_in;
  logic [DATA_W-1:0] rdata_out;
  logic [EVT_W-1:0] event_in;
  logic serr_enable_in;
  logic serr_n_out;
  logic irq_out;
  logic [15:0] low_cycles;
  int err_total;
  int samples_checked;
  int cycles = 0;
  logic [7:0] v;

  system_error_event_mask u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .event_in(event_in), .serr_enable_in(serr_enable_in),
    .serr_n_out(serr_n_out), .irq_out(irq_out));
  serr_host_model u_host (.clk_in(clk_in), .rst_n_in(rst_n_in), .serr_n_in(serr_n_out), .low_cycles_out(low_cycles));

  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  task automatic results();
    $display("checked=%0d errors=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // A hung handshake would otherwise stall the run forever.
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_total = err_total + 1;
      results();
    end
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken just past that edge.
  task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    cmp(rdata_out, exp);
  endtask

  task automatic pulse(input logic [7:0] ev, input logic en, input logic exp_n);
    @(posedge clk_in);
    event_in <= ev;
    serr_enable_in <= en;
    @(posedge clk_in);
    event_in <= 8'h00;
    #1;
    cmp({31'h0, serr_n_out}, {31'h0, exp_n});
  endtask

  initial begin
    rst_n_in = 1'b0;
    addr_in = 8'h00;
    wdata_in = 32'h00000000;
    wr_in = 1'b0;
    rd_in = 1'b0;
    event_in = 8'h00;
    serr_enable_in = 1'b0;
    err_total = 0;
    samples_checked = 0;
    repeat (16) @(posedge clk_in);
    rst_n_in <= 1'b1;
    chk_reg(DISABLE_OFFSET, 32'h00000000);
    chk_reg(CAUSE_OFFSET, 32'h00000000);
    chk_reg(IRQ_MASK_OFFSET, 32'h00000000);
    wr(DISABLE_OFFSET, 32'hFFFFFFFF);
    chk_reg(DISABLE_OFFSET, 32'h0000007E);
    wr(DISABLE_OFFSET, 32'h00000000);
    chk_reg(DISABLE_OFFSET, 32'h00000000);
    wr(8'h70, 32'h000000FF);
    chk_reg(8'h70, 32'h00000000);
    for (int i = 0; i < 8; i++) begin
      v = 8'h01 << i;
      pulse(v, 1'b1, ~EVENT_BITS[i]);
      chk_reg(CAUSE_OFFSET, {24'h0, v & EVENT_BITS});
      wr(CAUSE_OFFSET, {24'h0, v});
      chk_reg(CAUSE_OFFSET, 32'h00000000);
      pulse(v, 1'b0, 1'b1);
      wr(DISABLE_OFFSET, {24'h0, v});
      pulse(v, 1'b1, 1'b1);
      chk_reg(CAUSE_OFFSET, 32'h00000000);
      wr(DISABLE_OFFSET, 32'h00000000);
    end
    // An enabled event must still pull the line low beside one whose disable bit is set.
    wr(DISABLE_OFFSET, 32'h00000004);
    pulse(8'h06, 1'b1, 1'b0);
    chk_reg(CAUSE_OFFSET, 32'h00000002);
    wr(CAUSE_OFFSET, 32'h000000FF);
    wr(DISABLE_OFFSET, 32'h00000000);
    wr(IRQ_MASK_OFFSET, 32'h00000002);
    pulse(8'h02, 1'b1, 1'b0);
    @(posedge clk_in);
    #1;
    cmp({31'h0, irq_out}, 32'h00000001);
    wr(CAUSE_OFFSET, 32'h00000002);
    @(posedge clk_in);
    #1;
    cmp({31'h0, irq_out}, 32'h00000000);
    cmp({16'h0, low_cycles}, 32'h00000008);
    // A second reset in mid-run must bring the registers back to zero.
    wr(DISABLE_OFFSET, 32'h0000007E);
    wr(IRQ_MASK_OFFSET, 32'h0000007E);
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    chk_reg(DISABLE_OFFSET, 32'h00000000);
    chk_reg(IRQ_MASK_OFFSET, 32'h00000000);
    chk_reg(CAUSE_OFFSET, 32'h00000000);
    results();
  end
endmodule // system_error_event_mask_tb
